//--- rtl/pmsw_pkg.sv
// power mode, sleep and wake sequencing: shared constants and types
// assumes a 40 MHz core clock and a serial link clocked by the host
package pmsw_pkg;

    // ==========================================================
    // timing
    localparam int CLK_MHZ        = 40;
    localparam int REG_SETTLE_NS  = 5000;   // supply settle before ready shows
    localparam int REG_SETTLE_CYC = (REG_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_INIT_NS   = 20000;  // start-up after deep-sleep wake
    localparam int WAKE_INIT_CYC  = (WAKE_INIT_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W          = 10;

    // ==========================================================
    // register map on the serial link
    localparam logic [6:0] ADDR_PWR_MODE = 7'h02;
    localparam logic [6:0] ADDR_OSC_TUNE = 7'h04;

    // power mode register fields and reset value
    localparam int         MODE_LSB       = 0;
    localparam int         OSC_EN_BIT     = 5;
    localparam int         SOFT_RST_BIT   = 7;
    localparam logic [7:0] PWR_MODE_RESET = 8'h20;  // oscillator on, power-down
    localparam logic [5:0] OSC_TUNE_RESET = 6'h00;

    // power status byte bit positions
    localparam int READY_BIT    = 0;
    localparam int BROWNOUT_BIT = 1;

    // mode codes
    localparam logic [3:0] MODE_POWERDOWN = 4'h0;
    localparam logic [3:0] MODE_DEEPSLEEP = 4'h1;
    localparam logic [3:0] MODE_STANDBY   = 4'h5;

    // ==========================================================
    // types
    typedef struct packed {
        logic       wr;
        logic [6:0] addr;
        logic [7:0] data;
    } pmsw_cmd_s;

    typedef enum logic [1:0] {PMSW_RUN, PMSW_SLEEP, PMSW_WAKE} pmsw_state_e;

    // analog rails need at least standby; the digital core is off in both low modes
    function automatic logic core_on(input logic [3:0] mode);
        return (mode != MODE_POWERDOWN) && (mode != MODE_DEEPSLEEP);
    endfunction

endpackage

//--- rtl/pmsw_spi_link.sv
// serial link slave: 16-bit frames {write, address[6:0], data[7:0]}
// assumes sclk runs only while sel_n is low; first bit sampled on first rising edge
`timescale 1ns/10ps
module pmsw_spi_link (
    // link pins
    input  wire logic               sclk,
    input  wire logic               rst_n,
    input  wire logic               sel_n,
    input  wire logic               mosi,
    output logic                    link_miso,
    // core side
    input  wire logic [1:0]         status,
    output pmsw_pkg::pmsw_cmd_s     cmd,
    output logic                    req_toggle
);

    // ==========================================================
    // frame shifter, cleared by the frame's own select
    logic        frame_rst_n;
    logic [4:0]  bit_cnt;
    logic [14:0] shift_in;
    logic [7:0]  shift_out;
    logic [1:0]  st_meta;
    logic [1:0]  st_sync;
    logic [7:0]  out_byte;

    // select high ends a frame even with no further clock edge
    assign frame_rst_n = rst_n & ~sel_n;
    assign out_byte    = {6'h00, st_sync};

    // status levels cross into the link clock; settled by the data phase
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            st_meta <= 2'h0;
            st_sync <= 2'h0;
        end else begin
            st_meta <= status;
            st_sync <= st_meta;
        end
    end

    // RQ12 device as slave
    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_cnt   <= 5'h00;
            shift_in  <= 15'h0000;
            shift_out <= 8'h00;
            link_miso <= 1'b0;
        end else begin
            shift_in <= {shift_in[13:0], mosi};
            if (bit_cnt != 5'h10) begin
                bit_cnt <= bit_cnt + 5'h01;
            end
            if (bit_cnt == 5'h07) begin
                link_miso <= out_byte[7];
                shift_out <= {out_byte[6:0], 1'b0};
            end else begin
                link_miso <= shift_out[7];
                shift_out <= {shift_out[6:0], 1'b0};
            end
        end
    end

    // the word stays put for a whole frame, long enough for the core to take it
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            cmd        <= '0;
            req_toggle <= 1'b0;
        end else if (!sel_n && bit_cnt == 5'h0f) begin
            cmd        <= pmsw_pkg::pmsw_cmd_s'({shift_in, mosi});
            req_toggle <= ~req_toggle;
        end
    end

endmodule // pmsw_spi_link

//--- rtl/pmsw_power_ctrl.sv
// power mode sequencer: supplies, oscillator, fifo gating, deep-sleep wake
// assumes mclk at 40 MHz; pins and the link arrive asynchronous to mclk
`timescale 1ns/10ps
// Notes on behaviour
// RQ1 - writing a new mode sets the supply enables to suit it
// RQ2 - a status flag shows the regulated supplies are ready
// RQ3 - a status flag shows the I/O supply fell below brown-out
// RQ4 - power-down keeps registers, refuses fifo access and flushes fifo
// RQ5 - host slows its serial clock to 100 ns during power-down
// RQ6 - deep sleep turns everything off and loses all register values
// RQ7 - select low wakes deep sleep; supplies start and all resets
// RQ8 - after wake, serial output held low, then high once ready
// RQ9 - host polls serial output high before normal accesses
// RQ10 - oscillator on at power-up, then follows the mode register
// RQ11 - six-bit tuning register selects oscillator load capacitance
// RQ12 - all configuration arrives over the serial link, device is slave
// RQ13 - host soft reset: select high, set then clear the reset bit
// RQ14 - power-on or soft reset returns every register to default
// RQ15 - in power-down fifo writes ignored and reads give zero
module pmsw_power_ctrl (
    // clock, reset, enable
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // serial link pins
    input  wire logic       sclk,
    input  wire logic       sel_n,
    input  wire logic       mosi,
    output logic            miso,
    output logic            miso_oe,
    // analog monitor
    input  wire logic       vddio_low,
    // supply and oscillator controls
    output logic            digital_supply_on,
    output logic            analog_supply_on,
    output logic            osc_en,
    output logic [5:0]      osc_tune,
    output logic [3:0]      power_mode,
    // power status
    output logic            regulator_ready,
    output logic            supply_brownout,
    // fifo gating
    input  wire logic       fifo_wr_req,
    input  wire logic       fifo_rd_req,
    input  wire logic [7:0] fifo_rd_word,
    output logic            fifo_wr,
    output logic            fifo_rd,
    output logic [7:0]      fifo_rd_data,
    output logic            fifo_allowed,
    output logic            fifo_flush
);

    // ==========================================================
    // link and crossings
    pmsw_pkg::pmsw_cmd_s   cmd;
    pmsw_pkg::pmsw_state_e state;
    pmsw_pkg::pmsw_state_e next_state;
    logic                  req_toggle;
    logic                  link_miso;
    logic [1:0]            sel_sync;
    logic [1:0]            bo_sync;
    logic [1:0]            miso_sync;
    logic [2:0]            req_sync;
    logic                  sel_prev;
    logic [7:0]            pwr_mode_reg;
    logic [5:0]            tune_reg;
    logic [7:0]            next_pwr;
    logic [5:0]            next_tune;
    logic [pmsw_pkg::CNT_W-1:0] settle_cnt;
    logic [pmsw_pkg::CNT_W-1:0] wake_cnt;
    logic                  wake_hold;

    pmsw_spi_link u_link (
        .sclk       (sclk),
        .rst_n      (rst_n),
        .sel_n      (sel_n),
        .mosi       (mosi),
        .link_miso  (link_miso),
        .status     ({supply_brownout, regulator_ready}),
        .cmd        (cmd),
        .req_toggle (req_toggle)
    );

    // two flops on every asynchronous level; first stage feeds only the second
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sel_sync  <= 2'h3;
            bo_sync   <= 2'h0;
            miso_sync <= 2'h0;
            req_sync  <= 3'h0;
            sel_prev  <= 1'b1;
        end else if (ce) begin
            sel_sync  <= {sel_sync[0], sel_n};
            bo_sync   <= {bo_sync[0], vddio_low};
            miso_sync <= {miso_sync[0], link_miso};
            req_sync  <= {req_sync[1:0], req_toggle};
            sel_prev  <= sel_sync[1];
        end
    end

    // ==========================================================
    // command decode and register next values
    wire       sel_low   = ~sel_sync[1];
    wire       sel_fall  = sel_prev & ~sel_sync[1];
    wire       cmd_stb   = req_sync[2] ^ req_sync[1];
    wire       running   = (state == pmsw_pkg::PMSW_RUN);
    wire       soft_held = pwr_mode_reg[pmsw_pkg::SOFT_RST_BIT];
    wire [3:0] mode      = pwr_mode_reg[pmsw_pkg::MODE_LSB +: 4];
    // RQ12 writes only via link
    wire       cmd_pwr   = running & cmd_stb & cmd.wr & (cmd.addr == pmsw_pkg::ADDR_PWR_MODE);
    wire       cmd_tune  = running & cmd_stb & cmd.wr & (cmd.addr == pmsw_pkg::ADDR_OSC_TUNE);
    wire       rst_write = cmd_pwr & cmd.data[pmsw_pkg::SOFT_RST_BIT];

    // RQ14 soft reset defaults
    wire [7:0] pwr_soft  = pmsw_pkg::PWR_MODE_RESET | (8'h01 << pmsw_pkg::SOFT_RST_BIT);
    // RQ6 sleep loses registers
    assign next_pwr  = !running  ? pmsw_pkg::PWR_MODE_RESET :
                       rst_write ? pwr_soft :
                       cmd_pwr   ? cmd.data : pwr_mode_reg;
    // RQ11 six-bit tuning field
    assign next_tune = (!running || rst_write || soft_held) ? pmsw_pkg::OSC_TUNE_RESET :
                       cmd_tune ? cmd.data[5:0] : tune_reg;

    // RQ7 wake on select low
    always_comb begin
        next_state = state;
        case (state)
            pmsw_pkg::PMSW_RUN: begin
                if (mode == pmsw_pkg::MODE_DEEPSLEEP) begin
                    next_state = pmsw_pkg::PMSW_SLEEP;
                end
            end
            pmsw_pkg::PMSW_SLEEP: begin
                if (sel_fall) begin
                    next_state = pmsw_pkg::PMSW_WAKE;
                end
            end
            pmsw_pkg::PMSW_WAKE: begin
                if (wake_cnt == '0) begin
                    next_state = pmsw_pkg::PMSW_RUN;
                end
            end
            // unused code falls back to run, where the defaults rebuild
            default: next_state = pmsw_pkg::PMSW_RUN;
        endcase
    end

    // RQ1 supply map from mode
    wire next_dig  = (running && pmsw_pkg::core_on(mode)) || state == pmsw_pkg::PMSW_WAKE;
    wire next_ana  = running && pmsw_pkg::core_on(mode) && mode >= pmsw_pkg::MODE_STANDBY;
    // RQ10 oscillator follows register
    wire next_osc  = running ? pwr_mode_reg[pmsw_pkg::OSC_EN_BIT] :
                     (state == pmsw_pkg::PMSW_WAKE);
    // RQ4 fifo only with core up
    wire next_fifo = running && pmsw_pkg::core_on(mode);
    wire supply_change = (next_dig != digital_supply_on) || (next_ana != analog_supply_on);

    // ==========================================================
    // registers and sequencing state; reset gives defaults, so the
    // oscillator is running straight out of power-on
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state        <= pmsw_pkg::PMSW_RUN;
            pwr_mode_reg <= pmsw_pkg::PWR_MODE_RESET;
            tune_reg     <= pmsw_pkg::OSC_TUNE_RESET;
        end else if (ce) begin
            state        <= next_state;
            pwr_mode_reg <= next_pwr;
            tune_reg     <= next_tune;
        end
    end

    // RQ2 settle count before ready
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            settle_cnt <= pmsw_pkg::CNT_W'(pmsw_pkg::REG_SETTLE_CYC);
        end else if (ce) begin
            if (supply_change) begin
                settle_cnt <= pmsw_pkg::CNT_W'(pmsw_pkg::REG_SETTLE_CYC);
            end else if (settle_cnt != '0) begin
                settle_cnt <= settle_cnt - 1'b1;
            end
        end
    end

    // RQ8 wake initialisation timer
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wake_cnt  <= '0;
            wake_hold <= 1'b0;
        end else if (ce) begin
            if (next_state == pmsw_pkg::PMSW_WAKE && state == pmsw_pkg::PMSW_SLEEP) begin
                wake_cnt <= pmsw_pkg::CNT_W'(pmsw_pkg::WAKE_INIT_CYC - 1);
            end else if (wake_cnt != '0) begin
                wake_cnt <= wake_cnt - 1'b1;
            end
            // ready level stays on the pin until the host lets select go
            wake_hold <= (state == pmsw_pkg::PMSW_WAKE && wake_cnt == '0) ||
                         (wake_hold && sel_low);
        end
    end

    // ==========================================================
    // registered outputs
    // RQ8 miso low then high; link bits pass through three flops, which take up
    // about 75 ns of the host's full period between rising edges, so link rate is capped by this
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            miso              <= 1'b0;
            miso_oe           <= 1'b0;
            digital_supply_on <= 1'b1;
            analog_supply_on  <= 1'b0;
            osc_en            <= 1'b1;
            osc_tune          <= pmsw_pkg::OSC_TUNE_RESET;
            power_mode        <= pmsw_pkg::MODE_POWERDOWN;
            regulator_ready   <= 1'b0;
            supply_brownout   <= 1'b0;
        end else if (ce) begin
            miso              <= (state == pmsw_pkg::PMSW_WAKE) ? 1'b0 :
                                 wake_hold ? 1'b1 : miso_sync[1];
            miso_oe           <= (state == pmsw_pkg::PMSW_WAKE) || wake_hold ||
                                 (running && sel_low);
            digital_supply_on <= next_dig;
            analog_supply_on  <= next_ana;
            osc_en            <= next_osc;
            osc_tune          <= tune_reg;
            power_mode        <= mode;
            // RQ2 ready after settle
            regulator_ready   <= digital_supply_on && !supply_change && settle_cnt == '0;
            // RQ3 brown-out flag
            supply_brownout   <= bo_sync[1];
        end
    end

    // RQ15 fifo gated in power-down
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fifo_wr      <= 1'b0;
            fifo_rd      <= 1'b0;
            fifo_rd_data <= 8'h00;
            fifo_allowed <= 1'b0;
            fifo_flush   <= 1'b0;
        end else if (ce) begin
            fifo_wr      <= fifo_wr_req & next_fifo;
            fifo_rd      <= fifo_rd_req & next_fifo;
            fifo_rd_data <= next_fifo ? fifo_rd_word : 8'h00;
            fifo_allowed <= next_fifo;
            // RQ4 contents dropped when fifo access ends
            fifo_flush   <= fifo_allowed & ~next_fifo;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    mode_write_a: assert property (ce && cmd_pwr && !rst_write |=> // RQ1
        pwr_mode_reg == $past(cmd.data)) else $error("mode write not stored");
    ready_drop_a: assert property (ce && supply_change |=> // RQ2
        !regulator_ready) else $error("ready shown during supply change");
    brownout_a: assert property (ce && bo_sync[1] && $past(ce) |=> // RQ3
        supply_brownout) else $error("brown-out not reported");
    fifo_refuse_a: assert property (ce && running && mode == pmsw_pkg::MODE_POWERDOWN // RQ4
        |=> !fifo_wr && !fifo_rd && fifo_rd_data == 8'h00) else $error("fifo used in power-down");
    fifo_flush_a: assert property ($fell(fifo_allowed) |-> fifo_flush) // RQ4
        else $error("fifo not flushed");
    sleep_off_a: assert property (state == pmsw_pkg::PMSW_SLEEP && $past(ce) && // RQ6
        $past(state) == pmsw_pkg::PMSW_SLEEP |-> !digital_supply_on && !analog_supply_on &&
        pwr_mode_reg == pmsw_pkg::PWR_MODE_RESET) else $error("sleep kept state");
    wake_start_a: assert property (ce && state == pmsw_pkg::PMSW_SLEEP && sel_fall // RQ7
        |=> state == pmsw_pkg::PMSW_WAKE) else $error("no wake on select low");
    wake_low_a: assert property (ce && state == pmsw_pkg::PMSW_WAKE |=> // RQ8
        miso_oe && !miso) else $error("miso not low during wake");
    wake_high_a: assert property (ce && state == pmsw_pkg::PMSW_WAKE && wake_cnt == '0 // RQ8
        ##1 ce |=> miso_oe && miso) else $error("miso not high after wake");
    tune_write_a: assert property (ce && cmd_tune && !soft_held |=> // RQ11
        tune_reg == $past(cmd.data[5:0])) else $error("tuning write lost");
    soft_reset_a: assert property (soft_held |-> // RQ14
        tune_reg == pmsw_pkg::OSC_TUNE_RESET) else $error("soft reset left tuning");

    sleep_c: cover property (state == pmsw_pkg::PMSW_SLEEP);
    wake_done_c: cover property (state == pmsw_pkg::PMSW_WAKE ##1 state == pmsw_pkg::PMSW_RUN);
    flush_c: cover property (fifo_flush);
    soft_c: cover property ($rose(soft_held));

endmodule // pmsw_power_ctrl

//--- verification/pmsw_host_model.sv
// host side of the serial link: frame master and deep-sleep wake
// assumes the device samples mosi on sclk rising edges
`timescale 1ns/10ps
module pmsw_host_model (
    // link pins
    output logic      sclk,
    output logic      sel_n,
    output logic      mosi,
    // device answer
    input  wire logic miso,
    input  wire logic miso_oe
);
    logic miso_last;
    // a released line must not pass for the last driven bit
    wire  miso_line = miso_oe ? miso : ~miso_last;

    always @(miso or miso_oe) if (miso_oe) miso_last = miso;

    initial begin
        sclk      = 1'b0;
        sel_n     = 1'b1;
        mosi      = 1'b0;
        miso_last = 1'b0;
    end

    // ==========================================
    // frames
    // host masters at 160 ns
    task automatic frame(input logic w, input logic [6:0] a, input logic [7:0] d,
                         output logic [7:0] st);
        logic [15:0] word;
        word  = {w, a, d};
        st    = 8'h00;
        sel_n = 1'b0;
        #100;
        for (int i = 15; i >= 0; i--) begin
            mosi = word[i];
            #80;
            sclk = 1'b1;
            if (i < 8) st = {st[6:0], miso_line};
            #80;
            sclk = 1'b0;
        end
        #20;
        sel_n = 1'b1;
        mosi  = ~mosi;
        // select gap at least 100 ns
        #200;
    endtask

    task automatic wake_hold();
        sel_n = 1'b0;
    endtask

    task automatic wake_end();
        sel_n = 1'b1;
        #200;
    endtask
endmodule // pmsw_host_model

//--- verification/test_power_mode_sleep_wake_control.sv
// bench for the power mode sequencer with a bench model of its registers
// assumes pmsw_pkg and the host model are compiled first
`timescale 1ns/10ps
module test_power_mode_sleep_wake_control;
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic       vddio_low = 1'b0;
    logic       wr_req = 1'b0;
    logic       rd_req = 1'b0;
    logic [7:0] rd_word = 8'h00;
    wire        sclk, sel_n, mosi;
    logic       miso, miso_oe, dig, ana, osc_en, ready, brown;
    logic       ce = 1'b1;
    logic       fifo_wr, fifo_rd, allowed, flush;
    logic [5:0] tune;
    logic [3:0] mode;
    logic [7:0] rd_data, st, r;
    int         n_fail = 0, total_checks = 0, m_mode, m_osc, m_tune, m_soft, flushes, k;

    always #12.5 mclk = ~mclk;
    always @(posedge mclk) if (flush === 1'b1) flushes++;

    pmsw_power_ctrl u_pmsw_power_ctrl (.mclk(mclk), .rst_n(rst_n), .ce(ce),
        .sclk(sclk), .sel_n(sel_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
        .vddio_low(vddio_low), .digital_supply_on(dig), .analog_supply_on(ana),
        .osc_en(osc_en), .osc_tune(tune), .power_mode(mode), .regulator_ready(ready),
        .supply_brownout(brown), .fifo_wr_req(wr_req), .fifo_rd_req(rd_req),
        .fifo_rd_word(rd_word), .fifo_wr(fifo_wr), .fifo_rd(fifo_rd), .fifo_rd_data(rd_data),
        .fifo_allowed(allowed), .fifo_flush(flush));
    pmsw_host_model u_pmsw_host_model (.sclk(sclk), .sel_n(sel_n), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe));

    // ==========================================
    // reporting
    task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // a wait that used up its bound counts as a mismatch and ends the run
    task automatic wait_limit(input string n, input int lim);
        if (k >= lim) begin
            n_fail++;
            $display("wrong value %s expected below %0d seen %0d", n, lim, k);
            stop_test();
        end
    endtask

    // ==========================================
    // bench model: soft reset brings defaults back; deep sleep clears mode and tune and stops the oscillator
    task automatic model(input logic [6:0] a, input logic [7:0] d);
        if (a == pmsw_pkg::ADDR_PWR_MODE) begin
            m_soft = int'(d[pmsw_pkg::SOFT_RST_BIT]);
            m_mode = m_soft ? 0 : int'(d[3:0]);
            m_osc  = m_soft ? 1 : int'(d[pmsw_pkg::OSC_EN_BIT]);
            if (m_soft != 0) m_tune = 0;
        end else if (a == pmsw_pkg::ADDR_OSC_TUNE && m_soft == 0) m_tune = int'(d[5:0]);
        if (m_mode == 1) begin
            m_mode = 0;
            m_osc  = 0;  // deep sleep stops the oscillator as well
            m_tune = 0;
        end
    endtask

    // one write frame, then every register output against the model
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_pmsw_host_model.frame(1'b1, a, d, st);
        model(a, d);
        tick(6);
        check("power_mode", 8'(m_mode), {4'h0, mode});
        check("osc_en", 8'(m_osc), {7'h0, osc_en});
        check("osc_tune", 8'(m_tune), {2'h0, tune});
        check("digital_on", 8'(m_mode != 0), {7'h0, dig});
        check("analog_on", 8'(m_mode >= 5), {7'h0, ana});
    endtask

    initial begin
        void'($urandom(32'h3397842e));
        m_mode = 0;
        m_osc  = 1;
        m_tune = 0;
        m_soft = 0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        tick(2);
        check("osc_en", 8'h01, {7'h0, osc_en});
        check("osc_tune", 8'h00, {2'h0, tune});
        check("power_mode", 8'h00, {4'h0, mode});
        check("digital_on", 8'h00, {7'h0, dig});
        $display("test reset done");
        // power-down: fifo refused, registers still written
        @(posedge mclk);
        wr_req  <= 1'b1;
        rd_req  <= 1'b1;
        rd_word <= 8'($urandom);
        tick(2);
        check("fifo_wr", 8'h00, {7'h0, fifo_wr});
        check("fifo_rd", 8'h00, {7'h0, fifo_rd});
        check("fifo_rd_data", 8'h00, rd_data);
        check("fifo_allowed", 8'h00, {7'h0, allowed});
        for (int i = 0; i < 3; i++) wr(pmsw_pkg::ADDR_OSC_TUNE, 8'($urandom));
        wr(pmsw_pkg::ADDR_OSC_TUNE, 8'h3f);
        $display("test power-down done");
        // standby: supplies settle, fifo passes, status bits on miso
        wr(pmsw_pkg::ADDR_PWR_MODE, 8'h25);
        check("ready_early", 8'h00, {7'h0, ready});
        // enable low freezes the settle count, so ready must not show yet
        @(posedge mclk);
        ce <= 1'b0;
        tick(250);
        check("ready_frozen", 8'h00, {7'h0, ready});
        @(posedge mclk);
        ce <= 1'b1;
        for (k = 0; k < 400 && ready !== 1'b1; k++) tick(1);
        wait_limit("ready_wait", 400);
        check("ready", 8'h01, {7'h0, ready});
        total_checks++;
        // only enabled cycles count towards the settle time
        if (k < pmsw_pkg::REG_SETTLE_CYC - 20 || k > pmsw_pkg::REG_SETTLE_CYC) begin
            n_fail++;
            $display("wrong value settle_cycles expected %0d seen %0d",
                     pmsw_pkg::REG_SETTLE_CYC, k);
        end
        r = 8'($urandom);
        @(posedge mclk);
        rd_word <= r;
        tick(2);
        check("fifo_wr", 8'h01, {7'h0, fifo_wr});
        check("fifo_rd", 8'h01, {7'h0, fifo_rd});
        check("fifo_rd_data", r, rd_data);
        u_pmsw_host_model.frame(1'b0, 7'h00, 8'h00, st);
        check("status", 8'h01, st);
        @(posedge mclk);
        vddio_low <= 1'b1;
        tick(4);
        check("brownout", 8'h01, {7'h0, brown});
        u_pmsw_host_model.frame(1'b0, 7'h00, 8'h00, st);
        check("status", 8'h03, st);
        @(posedge mclk);
        vddio_low <= 1'b0;
        tick(4);
        check("brownout", 8'h00, {7'h0, brown});
        wr(pmsw_pkg::ADDR_PWR_MODE, 8'h23);
        check("ready_drop", 8'h00, {7'h0, ready});
        wr(pmsw_pkg::ADDR_PWR_MODE, 8'h05);
        $display("test standby done");
        // back to power-down: one flush pulse, tune kept
        flushes = 0;
        wr(pmsw_pkg::ADDR_PWR_MODE, 8'h20);
        check("flushes", 8'h01, 8'(flushes));
        check("fifo_wr", 8'h00, {7'h0, fifo_wr});
        // soft reset clears tune and locks it until released
        wr(pmsw_pkg::ADDR_PWR_MODE, 8'ha5);
        wr(pmsw_pkg::ADDR_OSC_TUNE, 8'h15);
        wr(pmsw_pkg::ADDR_PWR_MODE, 8'h05);
        wr(pmsw_pkg::ADDR_OSC_TUNE, 8'h2a);
        $display("test soft reset done");
        // deep sleep, then wake by select
        wr(pmsw_pkg::ADDR_PWR_MODE, 8'h01);
        check("miso_oe", 8'h00, {7'h0, miso_oe});
        u_pmsw_host_model.wake_hold();
        for (k = 0; k < 20 && miso_oe !== 1'b1; k++) tick(1);
        wait_limit("wake_drive", 20);
        check("wake_miso", 8'h00, {7'h0, miso});
        check("wake_digital", 8'h01, {7'h0, dig});
        for (k = 0; k < 1000 && miso !== 1'b1; k++) tick(1);
        wait_limit("wake_ready", 1000);
        if (k < pmsw_pkg::WAKE_INIT_CYC - 4 || k > pmsw_pkg::WAKE_INIT_CYC + 8) begin
            n_fail++;
            $display("wrong value wake_cycles expected %0d seen %0d", pmsw_pkg::WAKE_INIT_CYC, k);
        end
        total_checks++;
        u_pmsw_host_model.wake_end();
        tick(2);
        check("osc_tune", 8'h00, {2'h0, tune});
        check("power_mode", 8'h00, {4'h0, mode});
        check("osc_en", 8'h01, {7'h0, osc_en});
        $display("test deep sleep done");
        stop_test();
    end
endmodule // test_power_mode_sleep_wake_control
